// ### include/fdoa_pkg.sv
`default_nettype none
package fdoa_pkg;
    // register offsets
    localparam logic [7:0] FDOA_ADDR_CONFIG  = 8'h02;
    localparam logic [7:0] FDOA_ADDR_FLAGS   = 8'h05;
    localparam logic [7:0] FDOA_ADDR_MASK    = 8'h06;
    localparam logic [7:0] FDOA_ADDR_START   = 8'h07;
    localparam logic [7:0] FDOA_ADDR_CEILING = 8'h08;
    localparam logic [7:0] FDOA_ADDR_TARGET  = 8'h09;
    localparam logic [7:0] FDOA_ADDR_NOW     = 8'h0a;
    // reset values
    localparam logic [7:0] FDOA_RST_CONFIG   = 8'h00;
    localparam logic [7:0] FDOA_RST_FLAGS    = 8'h00;
    localparam logic [7:0] FDOA_RST_MASK     = 8'h00;
    localparam logic [7:0] FDOA_RST_START    = 8'h60;
    localparam logic [7:0] FDOA_RST_CEILING  = 8'hf0;
    localparam logic [7:0] FDOA_RST_TARGET   = 8'h00;
    localparam logic [7:0] FDOA_RST_NOW      = 8'h00;
    // field positions
    localparam int FDOA_BIT_REMOTE    = 7;
    localparam int FDOA_BIT_LOCAL     = 6;
    localparam int FDOA_BIT_TIMEOUT   = 5;
    localparam int FDOA_BIT_INVERT    = 4;
    localparam int FDOA_BIT_FLOOR     = 3;
    localparam int FDOA_BIT_SPIN_DIS  = 2;
    // duty scale
    localparam logic [7:0] FDOA_FULL_SCALE = 8'hf0;
    localparam logic [7:0] FDOA_RAMP_STEP  = 8'h02;
    localparam logic [7:0] FDOA_PWM_SLOTS  = 8'hf0;
    // timing
    localparam int FDOA_CLK_MHZ       = 250;
    localparam int FDOA_RATE_UNIT_US  = 62500;
    localparam int FDOA_SPIN_UP_US    = 2000000;
    localparam int FDOA_SLOT_NS       = 126260;
    localparam int FDOA_RATE_UNIT_CYC = FDOA_RATE_UNIT_US * FDOA_CLK_MHZ;
    localparam int FDOA_SPIN_UP_CYC   = FDOA_SPIN_UP_US * FDOA_CLK_MHZ;
    localparam int FDOA_SLOT_CYC      = (FDOA_SLOT_NS * FDOA_CLK_MHZ) / 1000;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } fdoa_req_s;

    typedef enum logic [0:0] {
        FDOA_SPIN_IDLE,
        FDOA_SPIN_RUN
    } fdoa_spin_e;
endpackage
`default_nettype wire

// ### tb/fdoa_host_model.sv
`default_nettype none
module fdoa_host_model (
    input  wire logic                clk,
    input  wire logic [7:0]          reg_rdata,
    output var  fdoa_pkg::fdoa_req_s reg_req
);
    timeunit 1ns;
    timeprecision 100ps;
    import fdoa_pkg::*;

    initial reg_req = '0;

    // single byte write, strobe held for exactly one sampling edge
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk) #1;
        reg_req.wr    = 1'b1;
        reg_req.addr  = a;
        reg_req.wdata = (a == FDOA_ADDR_CONFIG) ? {2'b00, d[5:0]} : d;
        @(posedge clk) #1;
        reg_req.wr    = 1'b0;
        reg_req.addr  = ~a;
        reg_req.wdata = ~reg_req.wdata;
    endtask

    // single byte read, data taken after the edge that took the request
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk) #1;
        reg_req.rd   = 1'b1;
        reg_req.addr = a;
        @(posedge clk) #1;
        reg_req.rd   = 1'b0;
        reg_req.addr = ~a;
        d            = reg_rdata;
    endtask

    // flag read followed by a temperature read, as a host must do
    task automatic rd_flags(output logic [7:0] d);
        logic [7:0] t;
        rd(FDOA_ADDR_FLAGS, d);
        rd(8'h00, t);
    endtask
endmodule // fdoa_host_model
`default_nettype wire

// ### tb/fdoa_top_tb.sv
`default_nettype none
module fdoa_top_tb;
    timeunit 1ns;
    timeprecision 100ps;
    import fdoa_pkg::*;

    logic clk = 0, srst = 1, meas_done = 0, remote_over = 0, local_over = 0;
    logic auto_below_start = 0;
    logic [1:0] fan_source = 0;
    logic [7:0] auto_steps = 0, reg_rdata, d;
    logic [4:0] step_duty = 0;
    logic [2:0] rate_code = 0;
    logic alert_o, alert_oe, bus_timeout_en, fan_drive_output;
    wire logic alert_pin;
    fdoa_req_s reg_req;
    int mismatches = 0, compares = 0;

    assign alert_pin = alert_oe ? alert_o : 1'b1; // pulled up when released
    always #2 clk = ~clk;

    fdoa_host_model host (.clk(clk), .reg_rdata(reg_rdata), .reg_req(reg_req));

    fdoa_top #(.RATE_UNIT_CYCLES(8), .SPIN_UP_CYCLES(16), .SLOT_CYCLES(2)) DUT (
        .clk(clk), .srst(srst), .reg_req(reg_req), .reg_rdata(reg_rdata),
        .meas_done(meas_done), .remote_over(remote_over), .local_over(local_over),
        .fan_source(fan_source), .auto_below_start(auto_below_start),
        .auto_steps(auto_steps), .step_duty(step_duty), .rate_code(rate_code),
        .overheat_alert_n_i(alert_pin), .overheat_alert_n_o(alert_o),
        .overheat_alert_n_oe(alert_oe), .bus_timeout_en(bus_timeout_en),
        .fan_drive_output(fan_drive_output));

    task automatic print_verdict();
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
        compares++;
        if (g !== e) begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic rchk(input logic [7:0] a, input logic [7:0] e);
        host.rd(a, d);
        chk($sformatf("reg %h", a), {8'h00, e}, {8'h00, d});
    endtask

    task automatic meas(input logic r, input logic l);
        @(posedge clk) #1;
        remote_over = r;
        local_over  = l;
        meas_done   = 1;
        @(posedge clk) #1;
        meas_done   = 0;
        @(posedge clk) #1;
    endtask

    task automatic settle();
        repeat (4) @(posedge clk);
        #1;
    endtask

    // counts high cycles of the fan output over one full pwm period
    task automatic pwm_chk(input logic [15:0] e);
        logic [15:0] n;
        n = 0;
        repeat (480) begin
            @(posedge clk) #1;
            if (fan_drive_output === 1'b1)
                n++;
        end
        chk("pwm high cycles", e, n);
    endtask

    task automatic t_reset();
        logic [7:0] a [8] = '{8'h02, 8'h05, 8'h06, 8'h07, 8'h08, 8'h09, 8'h0a, 8'h33};
        logic [7:0] e [8] = '{8'h00, 8'h00, 8'h00, 8'h60, 8'hf0, 8'h00, 8'h00, 8'h00};
        for (int i = 0; i < 8; i++) begin
            rchk(a[i], e[i]);
        end
        chk("timeout enable", 1, bus_timeout_en);
        host.wr(FDOA_ADDR_NOW, 8'h55);
        host.wr(FDOA_ADDR_FLAGS, 8'hff);
        rchk(FDOA_ADDR_NOW, 8'h00);
        rchk(FDOA_ADDR_FLAGS, 8'h00);
        $display("test reset done");
    endtask

    task automatic t_config();
        host.wr(FDOA_ADDR_CONFIG, 8'he0);
        rchk(FDOA_ADDR_CONFIG, 8'h20);
        chk("timeout enable", 0, bus_timeout_en);
        host.wr(FDOA_ADDR_CONFIG, 8'h00);
        settle();
        chk("timeout enable", 1, bus_timeout_en);
        $display("test config done");
    endtask

    task automatic t_alert();
        meas(1, 0);
        chk("alert pin", 0, alert_pin);
        meas(0, 0);
        chk("alert pin", 0, alert_pin);
        host.wr(FDOA_ADDR_FLAGS, 8'h00);
        host.rd_flags(d);
        chk("flags", 8'h80, d);
        chk("alert pin", 1, alert_pin);
        rchk(FDOA_ADDR_FLAGS, 8'h00);
        host.wr(FDOA_ADDR_MASK, 8'h40);
        meas(0, 1);
        chk("alert pin", 1, alert_pin);
        host.wr(FDOA_ADDR_MASK, 8'hc0);
        meas(1, 1);
        chk("alert pin", 1, alert_pin);
        host.rd_flags(d);
        chk("flags", 8'hc0, d);
        host.wr(FDOA_ADDR_MASK, 8'h00);
        meas(0, 1);
        host.rd_flags(d);
        chk("alert pin", 1, alert_pin);
        meas(0, 1);
        chk("alert pin", 0, alert_pin);
        host.rd_flags(d);
        chk("flags", 8'h40, d);
        $display("test alert done");
    endtask

    task automatic t_manual();
        host.wr(FDOA_ADDR_CONFIG, 8'h04);
        host.wr(FDOA_ADDR_CEILING, 8'h10);
        host.wr(FDOA_ADDR_TARGET, 8'h30);
        settle();
        rchk(FDOA_ADDR_NOW, 8'h30);
        host.wr(FDOA_ADDR_TARGET, 8'hff);
        settle();
        rchk(FDOA_ADDR_TARGET, 8'hf0);
        rchk(FDOA_ADDR_NOW, 8'hf0);
        pwm_chk(0);
        host.wr(FDOA_ADDR_CONFIG, 8'h14);
        pwm_chk(480);
        host.wr(FDOA_ADDR_TARGET, 8'h78);
        settle();
        pwm_chk(240);
        rate_code = 3'd1;
        host.wr(FDOA_ADDR_TARGET, 8'h88);
        repeat (20) @(posedge clk);
        host.rd(FDOA_ADDR_NOW, d);
        chk("ramp midway", 1, d > 8'h78 && d < 8'h88);
        repeat (80) @(posedge clk);
        rchk(FDOA_ADDR_NOW, 8'h88);
        rate_code = 3'd0;
        host.wr(FDOA_ADDR_CONFIG, 8'h00);
        host.wr(FDOA_ADDR_TARGET, 8'h00);
        settle();
        host.wr(FDOA_ADDR_TARGET, 8'h30);
        settle();
        rchk(FDOA_ADDR_NOW, 8'hf0);
        repeat (24) @(posedge clk);
        rchk(FDOA_ADDR_NOW, 8'h30);
        $display("test manual done");
    endtask

    task automatic t_auto();
        host.wr(FDOA_ADDR_CONFIG, 8'h04);
        host.wr(FDOA_ADDR_CEILING, 8'hf0);
        fan_source       = 2'b01;
        auto_below_start = 1;
        settle();
        rchk(FDOA_ADDR_TARGET, 8'h00);
        host.wr(FDOA_ADDR_CONFIG, 8'h0c);
        settle();
        rchk(FDOA_ADDR_TARGET, 8'h60);
        auto_below_start = 0;
        auto_steps       = 8'd2;
        step_duty        = 5'd5;
        host.wr(FDOA_ADDR_TARGET, 8'h11);
        settle();
        rchk(FDOA_ADDR_TARGET, 8'h6a);
        host.wr(FDOA_ADDR_CEILING, 8'h20);
        settle();
        rchk(FDOA_ADDR_NOW, 8'h20);
        host.wr(FDOA_ADDR_CEILING, 8'hff);
        host.wr(FDOA_ADDR_START, 8'hf5);
        settle();
        rchk(FDOA_ADDR_TARGET, 8'hf0);
        rchk(FDOA_ADDR_NOW, 8'hf0);
        $display("test auto done");
    endtask

    initial begin
        #50000;
        mismatches++;
        print_verdict();
    end

    initial begin
        repeat (8) @(posedge clk);
        #1 srst = 0;
        t_reset();
        t_config();
        t_alert();
        t_manual();
        t_auto();
        print_verdict();
    end
endmodule // fdoa_top_tb
`default_nettype wire

// ### verilog/fdoa_pwm.sv
`default_nettype none
module fdoa_pwm #(
    parameter int SLOT_CYCLES = fdoa_pkg::FDOA_SLOT_CYC
) (
    input  wire logic       clk,
    input  wire logic       srst,
    input  wire logic [7:0] duty,
    input  wire logic       invert,
    output var  logic       fan_drive_output
);
    import fdoa_pkg::*;

    logic [31:0] presc;
    logic [31:0] next_presc;
    logic [7:0]  slot;
    logic [7:0]  next_slot;
    logic        next_out;
    logic        active;

    always_comb begin
        next_presc = presc + 32'h0000_0001;
        next_slot  = slot;
        if (presc >= 32'(SLOT_CYCLES - 1)) begin
            next_presc = 32'h0000_0000;
            next_slot  = (slot >= FDOA_PWM_SLOTS - 8'h01) ? 8'h00 : slot + 8'h01; // R24
        end
        active   = (duty >= FDOA_FULL_SCALE) || (slot < duty); // R24
        next_out = invert ? active : ~active; // R7
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            presc            <= 32'h0000_0000;
            slot             <= 8'h00;
            fan_drive_output <= 1'b1;
        end else begin
            presc            <= next_presc;
            slot             <= next_slot;
            fan_drive_output <= next_out;
        end
    end

    full_duty_level_a: assert property (@(posedge clk) disable iff (srst) // R7
        (duty >= FDOA_FULL_SCALE) ##1 (duty >= FDOA_FULL_SCALE)
        |-> fan_drive_output == $past(invert))
        else $error("fan output not at full-duty level");
endmodule // fdoa_pwm
`default_nettype wire

// ### verilog/fdoa_top.sv
// Overview of operation
// R1 - measurement sets flag bit 7 for remote fault, bit 6 for local fault.
// R2 - fault flags clear only when the host reads the flag register.
// R3 - reading the flag register releases the alert pin to high impedance.
// R4 - fault still present at next measurement sets flags and alert again.
// R5 - host reads a temperature register after reading the flag register.
// R6 - config bit 5 low enables bus timeout, high disables it.
// R7 - config bit 4 picks fan output level held at full duty.
// R8 - floor bit low: zero duty below threshold, start duty at threshold, then rising.
// R9 - floor bit high: start duty below threshold, rising above it.
// R10 - config bit 2 high disables spin-up, low allows normal spin-up.
// R11 - host writes zero to config bits 7 and 6; bits 1 and 0 ignored.
// R12 - mask bits 7 and 6 keep remote and local faults off the alert pin.
// R13 - full scale is 240; start duty above 240 means full duty.
// R14 - ceiling caps automatic duty, values above 240 mean full cap.
// R15 - manual mode ignores the ceiling register.
// R16 - automatic mode target holds duty computed from temperature and step size.
// R17 - nonzero rate setting ramps actual duty toward target gradually.
// R18 - manual mode host writes target duty directly, used as output target.
// R19 - instantaneous register reads the duty currently driven on the fan output.
// R20 - fan source bits both zero select manual mode, otherwise automatic.
// R21 - rate field zero makes actual duty follow target at once.
// R22 - unmasked channel over its limit drives the alert pin low.
// R23 - manual target writes above 240 are clipped to 240.
// R24 - fan output high time follows duty code over 240 slots per period; with config bit 4 low the output is low for the duty slots.
`default_nettype none
module fdoa_top #(
    parameter int RATE_UNIT_CYCLES = fdoa_pkg::FDOA_RATE_UNIT_CYC,
    parameter int SPIN_UP_CYCLES   = fdoa_pkg::FDOA_SPIN_UP_CYC,
    parameter int SLOT_CYCLES      = fdoa_pkg::FDOA_SLOT_CYC
) (
    input  wire logic                clk,
    input  wire logic                srst,
    input  wire fdoa_pkg::fdoa_req_s reg_req,
    output var  logic [7:0]          reg_rdata,
    input  wire logic                meas_done,
    input  wire logic                remote_over,
    input  wire logic                local_over,
    input  wire logic [1:0]          fan_source,
    input  wire logic                auto_below_start,
    input  wire logic [7:0]          auto_steps,
    input  wire logic [4:0]          step_duty,
    input  wire logic [2:0]          rate_code,
    input  wire logic                overheat_alert_n_i,
    output var  logic                overheat_alert_n_o,
    output var  logic                overheat_alert_n_oe,
    output var  logic                bus_timeout_en,
    output var  logic                fan_drive_output
);
    import fdoa_pkg::*;

    // register file
    logic [7:0] config_byte;
    logic [7:0] overtemp_fault_flags;
    logic [7:0] overtemp_alert_mask;
    logic [7:0] fan_start_duty;
    logic [7:0] fan_duty_ceiling;
    logic [7:0] fan_duty_target;
    logic [7:0] ramp_duty;
    logic [7:0] next_config_byte;
    logic [7:0] next_overtemp_fault_flags;
    logic [7:0] next_overtemp_alert_mask;
    logic [7:0] next_fan_start_duty;
    logic [7:0] next_fan_duty_ceiling;
    logic [7:0] next_fan_duty_target;
    logic [7:0] next_ramp_duty;
    logic [7:0] next_reg_rdata;
    logic       next_alert_oe;
    logic       next_timeout_en;

    // duty datapath
    logic       manual_mode;
    logic       flags_read;
    logic       remote_evt;
    logic       local_evt;
    logic       alert_evt;
    logic [7:0] start_eff;
    logic [7:0] ceil_eff;
    logic [15:0] raw_sum;
    logic [7:0] auto_target;
    logic [7:0] drive_duty;

    // ramp and spin-up timers
    logic [31:0] rate_cnt;
    logic [31:0] next_rate_cnt;
    logic [31:0] rate_period;
    logic        rate_tick;
    logic [31:0] spin_cnt;
    logic [31:0] next_spin_cnt;
    fdoa_spin_e  spin_state;
    fdoa_spin_e  next_spin_state;

    assign manual_mode = (fan_source == 2'b00); // R20
    assign flags_read  = reg_req.rd && (reg_req.addr == FDOA_ADDR_FLAGS);
    assign remote_evt  = meas_done && remote_over; // R1
    assign local_evt   = meas_done && local_over; // R1
    assign alert_evt   = (remote_evt && !overtemp_alert_mask[FDOA_BIT_REMOTE]) // R12
                      || (local_evt && !overtemp_alert_mask[FDOA_BIT_LOCAL]); // R22

    // automatic duty computation
    always_comb begin
        start_eff = (fan_start_duty > FDOA_FULL_SCALE) ? FDOA_FULL_SCALE : fan_start_duty; // R13
        ceil_eff  = (fan_duty_ceiling > FDOA_FULL_SCALE) ? FDOA_FULL_SCALE
                                                         : fan_duty_ceiling; // R14
        raw_sum   = {8'h00, start_eff} + (16'(auto_steps) * 16'(step_duty)); // R16
        if (auto_below_start) begin
            auto_target = config_byte[FDOA_BIT_FLOOR] ? start_eff : 8'h00; // R8 R9
        end else if (raw_sum > 16'(FDOA_FULL_SCALE)) begin
            auto_target = FDOA_FULL_SCALE;
        end else begin
            auto_target = raw_sum[7:0]; // R8
        end
        if (auto_target > ceil_eff) begin
            auto_target = ceil_eff; // R14
        end
    end

    // register writes, flags and alert
    always_comb begin
        next_config_byte          = config_byte;
        next_overtemp_alert_mask  = overtemp_alert_mask;
        next_fan_start_duty       = fan_start_duty;
        next_fan_duty_ceiling     = fan_duty_ceiling;
        next_fan_duty_target      = fan_duty_target;
        next_overtemp_fault_flags = overtemp_fault_flags;
        next_alert_oe             = overheat_alert_n_oe;
        if (reg_req.wr) begin
            case (reg_req.addr)
                FDOA_ADDR_CONFIG:  next_config_byte = reg_req.wdata;
                FDOA_ADDR_MASK:    next_overtemp_alert_mask = reg_req.wdata;
                FDOA_ADDR_START:   next_fan_start_duty = reg_req.wdata;
                FDOA_ADDR_CEILING: next_fan_duty_ceiling = reg_req.wdata;
                default: ;
            endcase
        end
        if (manual_mode) begin
            if (reg_req.wr && reg_req.addr == FDOA_ADDR_TARGET) begin
                next_fan_duty_target = (reg_req.wdata > FDOA_FULL_SCALE) ? FDOA_FULL_SCALE
                                                                         : reg_req.wdata; // R18 R23
            end
        end else begin
            next_fan_duty_target = auto_target; // R15 R16
        end
        if (flags_read) begin
            next_overtemp_fault_flags = 8'h00; // R2
            next_alert_oe             = 1'b0; // R3
        end
        if (remote_evt) begin
            next_overtemp_fault_flags[FDOA_BIT_REMOTE] = 1'b1; // R1 R4
        end
        if (local_evt) begin
            next_overtemp_fault_flags[FDOA_BIT_LOCAL] = 1'b1; // R1 R4
        end
        if (alert_evt) begin
            next_alert_oe = 1'b1; // R4 R22
        end
        next_timeout_en = !config_byte[FDOA_BIT_TIMEOUT]; // R6
    end

    // read data
    always_comb begin
        case (reg_req.addr)
            FDOA_ADDR_CONFIG:  next_reg_rdata = config_byte;
            FDOA_ADDR_FLAGS:   next_reg_rdata = overtemp_fault_flags;
            FDOA_ADDR_MASK:    next_reg_rdata = overtemp_alert_mask;
            FDOA_ADDR_START:   next_reg_rdata = fan_start_duty;
            FDOA_ADDR_CEILING: next_reg_rdata = fan_duty_ceiling;
            FDOA_ADDR_TARGET:  next_reg_rdata = fan_duty_target;
            FDOA_ADDR_NOW:     next_reg_rdata = drive_duty; // R19
            default:           next_reg_rdata = 8'h00;
        endcase
        if (!reg_req.rd) begin
            next_reg_rdata = reg_rdata;
        end
    end

    // ramp of actual duty toward target
    always_comb begin
        rate_period = 32'(RATE_UNIT_CYCLES) << (rate_code - 3'd1);
        rate_tick   = (rate_cnt >= rate_period - 32'h0000_0001);
        next_rate_cnt  = rate_tick ? 32'h0000_0000 : rate_cnt + 32'h0000_0001;
        next_ramp_duty = ramp_duty;
        if (rate_code == 3'b000) begin
            next_rate_cnt  = 32'h0000_0000;
            next_ramp_duty = fan_duty_target; // R21
        end else if (rate_tick) begin
            if (fan_duty_target > ramp_duty + FDOA_RAMP_STEP) begin
                next_ramp_duty = ramp_duty + FDOA_RAMP_STEP; // R17
            end else if (fan_duty_target + FDOA_RAMP_STEP < ramp_duty) begin
                next_ramp_duty = ramp_duty - FDOA_RAMP_STEP; // R17
            end else begin
                next_ramp_duty = fan_duty_target;
            end
        end
    end

    // spin-up: full duty for a while when the fan starts from rest
    always_comb begin
        next_spin_state = spin_state;
        next_spin_cnt   = spin_cnt;
        case (spin_state)
            FDOA_SPIN_IDLE: begin
                if (ramp_duty == 8'h00 && next_ramp_duty != 8'h00
                    && !config_byte[FDOA_BIT_SPIN_DIS]) begin // R10
                    next_spin_state = FDOA_SPIN_RUN;
                    next_spin_cnt   = 32'h0000_0000;
                end
            end
            FDOA_SPIN_RUN: begin
                next_spin_cnt = spin_cnt + 32'h0000_0001;
                if (spin_cnt >= 32'(SPIN_UP_CYCLES - 1) || ramp_duty == 8'h00
                    || config_byte[FDOA_BIT_SPIN_DIS]) begin // R10
                    next_spin_state = FDOA_SPIN_IDLE;
                end
            end
            default: next_spin_state = FDOA_SPIN_IDLE;
        endcase
        drive_duty = (spin_state == FDOA_SPIN_RUN) ? FDOA_FULL_SCALE : ramp_duty; // R19
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            config_byte          <= FDOA_RST_CONFIG;
            overtemp_fault_flags <= FDOA_RST_FLAGS;
            overtemp_alert_mask  <= FDOA_RST_MASK;
            fan_start_duty       <= FDOA_RST_START;
            fan_duty_ceiling     <= FDOA_RST_CEILING;
            fan_duty_target      <= FDOA_RST_TARGET;
            ramp_duty            <= FDOA_RST_NOW;
            reg_rdata            <= 8'h00;
            overheat_alert_n_o   <= 1'b0;
            overheat_alert_n_oe  <= 1'b0;
            bus_timeout_en       <= 1'b1;
            rate_cnt             <= 32'h0000_0000;
            spin_cnt             <= 32'h0000_0000;
            spin_state           <= FDOA_SPIN_IDLE;
        end else begin
            config_byte          <= next_config_byte;
            overtemp_fault_flags <= next_overtemp_fault_flags;
            overtemp_alert_mask  <= next_overtemp_alert_mask;
            fan_start_duty       <= next_fan_start_duty;
            fan_duty_ceiling     <= next_fan_duty_ceiling;
            fan_duty_target      <= next_fan_duty_target;
            ramp_duty            <= next_ramp_duty;
            reg_rdata            <= next_reg_rdata;
            overheat_alert_n_o   <= 1'b0;
            overheat_alert_n_oe  <= next_alert_oe;
            bus_timeout_en       <= next_timeout_en;
            rate_cnt             <= next_rate_cnt;
            spin_cnt             <= next_spin_cnt;
            spin_state           <= next_spin_state;
        end
    end

    fdoa_pwm #(
        .SLOT_CYCLES(SLOT_CYCLES)
    ) u_pwm (
        .clk             (clk),
        .srst            (srst),
        .duty            (drive_duty),
        .invert          (config_byte[FDOA_BIT_INVERT]),
        .fan_drive_output(fan_drive_output)
    );

    // assertions
    sequence remote_fault_s;
        meas_done && remote_over;
    endsequence

    sequence flags_read_s;
        reg_req.rd && reg_req.addr == FDOA_ADDR_FLAGS;
    endsequence

    remote_flag_set_a: assert property (@(posedge clk) disable iff (srst) // R1
        remote_fault_s |=> overtemp_fault_flags[FDOA_BIT_REMOTE])
        else $error("remote fault flag not set");

    flag_sticky_a: assert property (@(posedge clk) disable iff (srst) // R2
        overtemp_fault_flags[FDOA_BIT_LOCAL] && !flags_read
        |=> overtemp_fault_flags[FDOA_BIT_LOCAL])
        else $error("local fault flag lost without a read");

    alert_release_a: assert property (@(posedge clk) disable iff (srst) // R3
        flags_read_s ##0 !meas_done |=> !overheat_alert_n_oe
                                         && overtemp_fault_flags == 8'h00)
        else $error("flag read did not release alert");

    alert_reassert_a: assert property (@(posedge clk) disable iff (srst) // R4
        flags_read_s ##[1:8] alert_evt
        |=> overheat_alert_n_oe && !overheat_alert_n_o)
        else $error("alert not driven again on persisting fault");

    masked_quiet_a: assert property (@(posedge clk) disable iff (srst) // R12
        !overheat_alert_n_oe && !alert_evt |=> !overheat_alert_n_oe)
        else $error("alert asserted without unmasked fault");

    timeout_bit_a: assert property (@(posedge clk) disable iff (srst) // R6
        reg_req.wr && reg_req.addr == FDOA_ADDR_CONFIG
        |=> ##1 bus_timeout_en == !$past(reg_req.wdata[FDOA_BIT_TIMEOUT], 2))
        else $error("timeout enable does not follow config bit");

    manual_clip_a: assert property (@(posedge clk) disable iff (srst) // R23
        manual_mode && reg_req.wr && reg_req.addr == FDOA_ADDR_TARGET
        |=> fan_duty_target == (($past(reg_req.wdata) > FDOA_FULL_SCALE)
                                ? FDOA_FULL_SCALE : $past(reg_req.wdata)))
        else $error("manual target not taken or not clipped");

    auto_ceiling_a: assert property (@(posedge clk) disable iff (srst) // R14
        !manual_mode |=> fan_duty_target <= $past(ceil_eff))
        else $error("automatic target above ceiling");

    instant_follow_a: assert property (@(posedge clk) disable iff (srst) // R21
        rate_code == 3'b000 |=> ramp_duty == $past(fan_duty_target))
        else $error("duty did not follow target at once");

    now_readback_a: assert property (@(posedge clk) disable iff (srst) // R19
        reg_req.rd && reg_req.addr == FDOA_ADDR_NOW |=> reg_rdata == $past(drive_duty))
        else $error("instantaneous duty readback wrong");
endmodule // fdoa_top
`default_nettype wire
